//--- hdl/gtc_pkg.sv
package gtc_pkg;

   // Register byte addresses
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_GATE = 8'h04;
   localparam logic [7:0] ADDR_CNT_LO = 8'h08;
   localparam logic [7:0] ADDR_CNT_HI = 8'h0c;
   localparam logic [7:0] ADDR_FLAGS = 8'h10;
   localparam logic [7:0] ADDR_IE = 8'h14;

   // Control register fields
   localparam int CTRL_ON = 0;
   localparam int CTRL_BYP = 2;
   localparam int CTRL_PSC = 4;
   localparam int CTRL_CS = 6;

   // Gate register fields
   localparam int GATE_SS = 0;
   localparam int GATE_VAL = 2;
   localparam int GATE_ARM = 3;
   localparam int GATE_SPM = 4;
   localparam int GATE_TM = 5;
   localparam int GATE_POL = 6;
   localparam int GATE_EN = 7;

   // Flag and enable bit positions
   localparam int FLG_OVF = 0;
   localparam int FLG_GATE = 1;

   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] GATE_RST = 8'h00;
   localparam logic [15:0] CNT_RST = 16'h0000;

   // Clock sources and gate sources
   localparam logic [1:0] CS_INSTR = 2'h0;
   localparam logic [1:0] CS_SYS = 2'h1;
   localparam logic [1:0] CS_EXT = 2'h2;
   localparam logic [1:0] GS_PIN = 2'h0;
   localparam logic [1:0] GS_SIB = 2'h1;
   localparam logic [1:0] GS_PER = 2'h2;
   localparam logic [1:0] GS_WDT = 2'h3;

   // Instruction clock is the system clock divided by this
   localparam int INSTR_DIV = 4;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Gate source inputs, bit order wdt, period, sibling, pin
   typedef struct packed {
      logic wdt_ovf;
      logic per_reset;
      logic sib_wrap;
      logic pin;
   } gtc_gsrc_s;

   // Whole state of the timer block
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] gate;
      logic [15:0] cnt;
      logic [1:0] ie;
      logic [1:0] flags;
      logic [7:0] div;
      logic [2:0] psc;
      logic ext_s1;
      logic ext_s2;
      logic ext_byp;
      logic ext_d;
      logic [3:0] src_s1;
      logic [3:0] src_s2;
      logic [3:0] src_d;
      logic act_d;
      logic tog;
      logic g1_d;
      logic sp_run;
      logic lvl;
      logic ovf_irq;
      logic gate_irq;
      logic wake;
      logic wdt_osc_en;
      logic rst_allow;
      logic aw_hold;
      logic [7:0] awaddr;
      logic w_hold;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } gtc_state_s;

endpackage : gtc_pkg

//--- hdl/gtc_timer.sv
`timescale 1ns/100ps
module gtc_timer
   import gtc_pkg::*;
#(
   parameter int DIV = INSTR_DIV
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ext_clk_in,
   input wire gtc_gsrc_s gate_src,
   input wire logic cpu_sleep,
   input wire logic watchdog_fuse_en,
   output logic [15:0] time_base,
   output logic overflow_irq,
   output logic gate_event_irq,
   output logic wake_req,
   output logic wdt_osc_en,
   output logic wdt_reset_allow
);

   // Divider must be a power of two that fits its counter
   if (DIV < 2 || DIV > 256 || (DIV & (DIV - 1)) != 0)
   begin : g_div_chk
      $error("gtc_timer: DIV must be a power of two, 2..256");
   end

   localparam logic [7:0] DIV_LAST = 8'(DIV - 1);

   gtc_state_s st_ff;
   gtc_state_s nxt_st;

   // Prescale terminal count for a select value
   function automatic logic [2:0] psc_last(input logic [1:0] sel);
      psc_last = 3'((4'h1 << sel) - 4'h1);
   endfunction : psc_last

   // Register read mux, shared by the read channel
   function automatic logic [31:0] reg_read(input gtc_state_s s,
                                            input logic [7:0] a);
      logic [7:0] g;
      g = s.gate;
      g[GATE_VAL] = s.lvl;
      case (a)
         ADDR_CTRL: reg_read = {24'h000000, s.ctrl};
         ADDR_GATE: reg_read = {24'h000000, g};
         ADDR_CNT_LO: reg_read = {24'h000000, s.cnt[7:0]};
         ADDR_CNT_HI: reg_read = {24'h000000, s.cnt[15:8]};
         ADDR_FLAGS: reg_read = {30'h0, s.flags};
         ADDR_IE: reg_read = {30'h0, s.ie};
         default: reg_read = 32'h00000000;
      endcase
   endfunction : reg_read

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == ADDR_CTRL) || (a == ADDR_GATE) ||
                (a == ADDR_CNT_LO) || (a == ADDR_CNT_HI) ||
                (a == ADDR_FLAGS) || (a == ADDR_IE);
   endfunction : addr_ok

   // Working signals of the next-state process
   logic do_wr;
   logic wr_lo;
   logic wr_hi;
   logic wr_cnt;
   logic [1:0] cs;
   logic [1:0] ss;
   logic ext_lvl;
   logic src_tick;
   logic en;
   logic inc;
   logic sel_src;
   logic act;
   logic g1;
   logic rise;
   logic [1:0] flag_set;
   logic [1:0] flag_clr;
   logic [3:0] src_rise;

   // Whole block next state
   always_comb
   begin
      nxt_st = st_ff;
      do_wr = st_ff.aw_hold && st_ff.w_hold && !st_ff.bvalid;
      wr_lo = do_wr && st_ff.wstrb[0] && st_ff.awaddr == ADDR_CNT_LO;
      wr_hi = do_wr && st_ff.wstrb[0] && st_ff.awaddr == ADDR_CNT_HI;
      wr_cnt = wr_lo || wr_hi;
      flag_set = 2'h0;
      flag_clr = 2'h0;

      // Write address and data are held separately, either order
      if (s_axi_awvalid && st_ff.awready)
      begin
         nxt_st.aw_hold = 1'b1;
         nxt_st.awaddr = s_axi_awaddr;
         nxt_st.awready = 1'b0;
      end
      if (s_axi_wvalid && st_ff.wready)
      begin
         nxt_st.w_hold = 1'b1;
         nxt_st.wdata = s_axi_wdata;
         nxt_st.wstrb = s_axi_wstrb;
         nxt_st.wready = 1'b0;
      end
      if (do_wr)
      begin
         nxt_st.aw_hold = 1'b0;
         nxt_st.w_hold = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = addr_ok(st_ff.awaddr) ? RESP_OKAY : RESP_SLVERR;
      end
      // Channels reopen only once the response is taken
      if (st_ff.bvalid && s_axi_bready)
      begin
         nxt_st.bvalid = 1'b0;
         nxt_st.awready = 1'b1;
         nxt_st.wready = 1'b1;
      end

      // Read answers one cycle after the address is taken
      if (s_axi_arvalid && st_ff.arready)
      begin
         nxt_st.arready = 1'b0;
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata = reg_read(st_ff, s_axi_araddr);
         nxt_st.rresp = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (st_ff.rvalid && s_axi_rready)
      begin
         nxt_st.rvalid = 1'b0;
         nxt_st.arready = 1'b1;
      end

      // Register writes; byte lane 0 only
      if (do_wr && st_ff.wstrb[0])
      begin
         case (st_ff.awaddr)
            ADDR_CTRL: nxt_st.ctrl = st_ff.wdata[7:0];
            ADDR_GATE:
            begin
               nxt_st.gate = st_ff.wdata[7:0];
               nxt_st.gate[GATE_VAL] = 1'b0;
            end
            ADDR_IE: nxt_st.ie = st_ff.wdata[1:0];
            ADDR_FLAGS: flag_clr = st_ff.wdata[1:0];
            default: ;
         endcase
      end
      cs = nxt_st.ctrl[CTRL_CS+:2];
      ss = st_ff.gate[GATE_SS+:2];

      // Gate inputs pass a two-stage synchroniser
      nxt_st.src_s1 = gate_src;
      nxt_st.src_s2 = st_ff.src_s1;
      nxt_st.src_d = st_ff.src_s2;
      src_rise = st_ff.src_s2 & ~st_ff.src_d;
      case (ss)
         GS_PIN: sel_src = st_ff.src_s2[0];
         GS_SIB: sel_src = src_rise[1];
         GS_PER: sel_src = src_rise[2];
         default: sel_src = st_ff.src_s2[3];
      endcase
      act = (sel_src == st_ff.gate[GATE_POL]);

      // Toggle stage flips on each rising edge of the active gate
      nxt_st.act_d = act;
      if (!st_ff.gate[GATE_TM])
      begin
         nxt_st.tog = 1'b0;
      end
      else if (act && !st_ff.act_d)
      begin
         nxt_st.tog = !st_ff.tog;
      end
      g1 = st_ff.gate[GATE_TM] ? st_ff.tog : act;
      nxt_st.g1_d = g1;
      rise = g1 && !st_ff.g1_d;

      // Single pulse window opens on an armed edge, ends on a fall
      if (!st_ff.gate[GATE_SPM])
      begin
         nxt_st.gate[GATE_ARM] = 1'b0;
         nxt_st.sp_run = 1'b0;
      end
      else if (st_ff.gate[GATE_ARM] && rise && !st_ff.sp_run)
      begin
         nxt_st.sp_run = 1'b1;
      end
      else if (st_ff.sp_run && !g1)
      begin
         nxt_st.sp_run = 1'b0;
         nxt_st.gate[GATE_ARM] = 1'b0;
      end
      // A new arm written this cycle wins over the hardware clear
      if (do_wr && st_ff.wstrb[0] && st_ff.awaddr == ADDR_GATE)
      begin
         nxt_st.gate[GATE_ARM] = st_ff.wdata[GATE_ARM] &&
                                 st_ff.wdata[GATE_SPM];
      end
      nxt_st.lvl = st_ff.gate[GATE_SPM] ? (g1 && nxt_st.sp_run) : g1;
      // Event flag works with gating enabled or not
      flag_set[FLG_GATE] = st_ff.lvl && !nxt_st.lvl;

      // Clock sources
      nxt_st.ext_s1 = ext_clk_in;
      nxt_st.ext_s2 = st_ff.ext_s1;
      nxt_st.ext_byp = ext_clk_in;
      // Bypass path is one register shorter; a switch can slip a count
      ext_lvl = st_ff.ctrl[CTRL_BYP] ? st_ff.ext_byp : st_ff.ext_s2;
      nxt_st.ext_d = ext_lvl;
      nxt_st.div = (st_ff.div == DIV_LAST) ? 8'h00 : st_ff.div + 8'h01;
      case (st_ff.ctrl[CTRL_CS+:2])
         CS_SYS: src_tick = 1'b1;
         CS_INSTR: src_tick = (st_ff.div == DIV_LAST);
         CS_EXT: src_tick = ext_lvl && !st_ff.ext_d;
         default: src_tick = 1'b0;
      endcase
      // Only the unsynced external clock keeps counting in sleep
      if (cpu_sleep && !(st_ff.ctrl[CTRL_BYP] &&
                         st_ff.ctrl[CTRL_CS+:2] == CS_EXT))
      begin
         src_tick = 1'b0;
      end

      // Count enable: timer on, gate permitting
      en = st_ff.ctrl[CTRL_ON] &&
           (!st_ff.gate[GATE_EN] || st_ff.lvl);
      inc = en && src_tick &&
            (st_ff.psc == psc_last(st_ff.ctrl[CTRL_PSC+:2]));
      if (wr_cnt)
      begin
         nxt_st.psc = 3'h0;
      end
      else if (en && src_tick)
      begin
         nxt_st.psc = inc ? 3'h0 : st_ff.psc + 3'h1;
      end
      if (inc)
      begin
         nxt_st.cnt = st_ff.cnt + 16'h0001;
         flag_set[FLG_OVF] = (st_ff.cnt == 16'hffff);
      end
      // Software write to a byte wins over a same-cycle increment
      if (wr_lo)
      begin
         nxt_st.cnt[7:0] = st_ff.wdata[7:0];
      end
      if (wr_hi)
      begin
         nxt_st.cnt[15:8] = st_ff.wdata[7:0];
      end

      // Sticky flags: hardware set beats a write-one clear
      nxt_st.flags = (st_ff.flags & ~flag_clr) | flag_set;
      nxt_st.ovf_irq = nxt_st.flags[FLG_OVF] && nxt_st.ie[FLG_OVF];
      nxt_st.gate_irq = nxt_st.flags[FLG_GATE] &&
                        nxt_st.ie[FLG_GATE];
      nxt_st.wake = cpu_sleep && nxt_st.ovf_irq;

      // Watchdog oscillator follows gate use, not the timer-on bit
      nxt_st.wdt_osc_en = nxt_st.gate[GATE_EN] &&
                          nxt_st.gate[GATE_SS+:2] == GS_WDT;
      // Reset permission only from the fuse, never from gate use
      nxt_st.rst_allow = watchdog_fuse_en;
      if (cs == 2'h3)
      begin
         nxt_st.ctrl[CTRL_CS+:2] = cs;
      end
   end

   // State register, synchronous reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_ff <= '0;
         st_ff.ctrl <= CTRL_RST;
         st_ff.gate <= GATE_RST;
         st_ff.cnt <= CNT_RST;
         st_ff.awready <= 1'b1;
         st_ff.wready <= 1'b1;
         st_ff.arready <= 1'b1;
         st_ff.bresp <= RESP_OKAY;
         st_ff.rresp <= RESP_OKAY;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from flip-flops
   assign s_axi_awready = st_ff.awready;
   assign s_axi_wready = st_ff.wready;
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_arready = st_ff.arready;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rdata = st_ff.rdata;
   assign s_axi_rresp = st_ff.rresp;
   assign time_base = st_ff.cnt;
   assign overflow_irq = st_ff.ovf_irq;
   assign gate_event_irq = st_ff.gate_irq;
   assign wake_req = st_ff.wake;
   assign wdt_osc_en = st_ff.wdt_osc_en;
   assign wdt_reset_allow = st_ff.rst_allow;

endmodule : gtc_timer

//--- verification/gtc_monitor.sv
`timescale 1ns/100ps
module gtc_monitor
   import gtc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic cpu_sleep,
   input wire logic watchdog_fuse_en,
   input wire logic [15:0] time_base,
   input wire logic overflow_irq,
   input wire logic gate_event_irq,
   input wire logic wake_req,
   input wire logic wdt_reset_allow
);
   default clocking mon_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Count only steps by one unless a write just landed
   property p_step;
      !s_axi_bvalid && $changed(time_base)
         |-> time_base == $past(time_base) + 16'h0001;
   endproperty
   a_step: assert property (p_step)
      else $error("count jumped");
   // Wake needs sleep and a pending overflow
   property p_wake;
      wake_req |-> $past(cpu_sleep) && (overflow_irq || $past(overflow_irq));
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake without cause");
   property p_awake;
      !cpu_sleep [*2] |-> !wake_req;
   endproperty
   a_awake: assert property (p_awake)
      else $error("wake while running");
   // Reset permission follows the fuse, never the gate use
   property p_fuse;
      (watchdog_fuse_en [*2] |-> wdt_reset_allow) and
      (!watchdog_fuse_en [*2] |-> !wdt_reset_allow);
   endproperty
   a_fuse: assert property (p_fuse)
      else $error("reset permission wrong");
   property p_b_aw;
      s_axi_bvalid |-> !s_axi_awready;
   endproperty
   a_b_aw: assert property (p_b_aw)
      else $error("address taken during response");
   property p_ar;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_ar: assert property (p_ar)
      else $error("read answer late");
   property p_r_done;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
   endproperty
   a_r_done: assert property (p_r_done)
      else $error("read not retired");
   property p_unmap;
      s_axi_arvalid && s_axi_arready && s_axi_araddr > ADDR_IE
         |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000;
   endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped read answered");
   c_wrap: cover property (time_base == 16'h0000 && $past(time_base) == 16'hffff);
   c_gate: cover property (gate_event_irq);
   c_wake: cover property (wake_req);
endmodule : gtc_monitor

//--- verification/gtc_partner.sv
`timescale 1ns/100ps
module gtc_partner
   import gtc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ext_en,
   input wire logic pin_lvl,
   input wire logic wdt_osc_en,
   output logic ext_clk_in,
   output gtc_gsrc_s gate_src
);
   // Period timer match value, short to keep runs brief
   localparam logic [5:0] PER_MATCH = 6'h31;
   logic [7:0] sib_ff;
   logic [5:0] per_ff;
   logic [6:0] wdt_ff;
   logic [2:0] ext_ff;
   // Neighbour timers; watchdog only counts while powered
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         sib_ff <= 8'h01;
         per_ff <= 6'h01;
         wdt_ff <= 7'h00;
         ext_ff <= 3'h0;
      end
      else
      begin
         sib_ff <= sib_ff + 8'h01;
         per_ff <= (per_ff == PER_MATCH) ? 6'h00 : per_ff + 6'h01;
         wdt_ff <= wdt_osc_en ? wdt_ff + 7'h01 : 7'h00;
         ext_ff <= ext_en ? ext_ff + 3'h1 : 3'h0;
      end
   // Pin clock of 8 cycles, parked low when unused
   assign ext_clk_in = ext_ff[2];
   assign gate_src.pin = pin_lvl;
   assign gate_src.sib_wrap = (sib_ff == 8'h00);
   assign gate_src.per_reset = (per_ff == 6'h00);
   // Wide overflow pulse, hence toggle use on this source
   assign gate_src.wdt_ovf = wdt_osc_en && (wdt_ff[6:5] == 2'h3);
endmodule : gtc_partner

//--- verification/test_gtc_timer.sv
`timescale 1ns/100ps
module test_gtc_timer;
   import gtc_pkg::*;
`define CHK(g, e) \
   begin num_checks++; if ((g) !== (e)) begin err_total++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
   typedef struct {logic [31:0] v; int tol;} gtc_exp_s;
   logic aclk = 1'h0, aresetn = 1'h0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic ext_clk_in, cpu_sleep = 1'h0, watchdog_fuse_en = 1'h0;
   logic ext_en = 1'h0, pin_lvl = 1'h0;
   gtc_gsrc_s gate_src;
   logic [15:0] time_base;
   logic overflow_irq, gate_event_irq, wake_req, wdt_osc_en, wdt_reset_allow;
   int err_total = 0, num_checks = 0, cs, p, s, n;
   int dv [3] = '{INSTR_DIV, 1, 8};
   logic [7:0] rst_a [6] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
   logic [31:0] seed = 32'h000080c6;
   gtc_exp_s exp_q [$];

   always #10 aclk = ~aclk;

   gtc_timer #(.DIV(INSTR_DIV)) gtc_timer_i (.*);
   gtc_partner gtc_partner_i (.aclk(aclk), .aresetn(aresetn),
      .ext_en(ext_en), .pin_lvl(pin_lvl), .wdt_osc_en(wdt_osc_en),
      .ext_clk_in(ext_clk_in), .gate_src(gate_src));

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      begin
         t = v ^ (v << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction : xs

   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", num_checks, err_total);
         if (err_total == 0 && num_checks > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask : wrap_up

   task tmo;
      begin
         err_total++;
         wrap_up();
      end
   endtask : tmo

   // Write: address and data together, each dropped once taken
   task wr(input logic [7:0] a, input logic [7:0] d);
      int k;
      logic done;
      begin
         done = 1'b0;
         @(posedge aclk);
         s_axi_awaddr <= a;
         s_axi_wdata <= {24'h000000, d};
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid <= 1'h1;
         s_axi_bready <= 1'h1;
         for (k = 0; !done; k++)
         begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid)
            begin
               `CHK(s_axi_bresp, RESP_OKAY)
               s_axi_bready <= 1'h0;
               done = 1'b1;
            end
            if (k > 60) tmo();
         end
      end
   endtask : wr

   // Read: note the expectation first, the watcher compares
   task rd(input logic [7:0] a, input logic [31:0] e, input int tol);
      int k;
      logic done;
      begin
         done = 1'b0;
         exp_q.push_back('{e, tol});
         @(posedge aclk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'h1;
         s_axi_rready <= 1'h1;
         for (k = 0; !done; k++)
         begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid)
            begin
               s_axi_rready <= 1'h0;
               done = 1'b1;
            end
            if (k > 60) tmo();
         end
      end
   endtask : rd

   // Counts from zero for a fixed span of 128 cycles
   task span(input logic [7:0] c);
      begin
         wr(ADDR_CNT_HI, 8'h00);
         wr(ADDR_CNT_LO, 8'h00);
         wr(ADDR_CTRL, c);
         repeat (124) @(posedge aclk);
         wr(ADDR_CTRL, c & 8'hfe);
      end
   endtask : span

   task pulse;
      begin
         repeat (10) @(posedge aclk);
         pin_lvl <= 1'h1;
         repeat (20) @(posedge aclk);
         pin_lvl <= 1'h0;
      end
   endtask : pulse

   // Oldest note against each read answer; tolerance absorbs phase
   always @(posedge aclk)
      if (s_axi_rvalid && s_axi_rready)
      begin : cmp
         gtc_exp_s x;
         logic [31:0] g;
         x = exp_q.pop_front();
         g = s_axi_rdata;
         if (g - x.v <= x.tol || x.v - g <= x.tol) g = x.v;
         `CHK(g, x.v)
      end

   initial
   begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      foreach (rst_a[i]) rd(rst_a[i], 32'h0, 0);
      $display("test reset done");
      for (cs = 0; cs < 3; cs++)
         for (p = 0; p < 4; p++)
         begin
            ext_en <= (cs == 2);
            span({cs[1:0], p[1:0], 1'h0, cs == 2 && p[0], 2'h1});
            rd(ADDR_CNT_LO, 128 / (dv[cs] << p), 2);
         end
      span(8'hc1);
      rd(ADDR_CNT_LO, 32'h0, 0);
      $display("test clock done");
      wr(ADDR_GATE, 8'hc0);
      span(8'h41);
      rd(ADDR_CNT_LO, 32'h0, 0);
      wr(ADDR_GATE, 8'h80);
      span(8'h41);
      rd(ADDR_CNT_LO, 32'h80, 2);
      wr(ADDR_GATE, 8'h40);
      pin_lvl <= 1'h1;
      repeat (8) @(posedge aclk);
      rd(ADDR_GATE, 32'h44, 0);
      wr(ADDR_FLAGS, 8'h03);
      wr(ADDR_IE, 8'h02);
      pin_lvl <= 1'h0;
      repeat (8) @(posedge aclk);
      `CHK(gate_event_irq, 1'h1)
      rd(ADDR_FLAGS, 32'h2, 0);
      wr(ADDR_FLAGS, 8'h02);
      rd(ADDR_FLAGS, 32'h0, 0);
      $display("test gate done");
      wr(ADDR_GATE, 8'hd8);
      wr(ADDR_CNT_LO, 8'h00);
      wr(ADDR_CTRL, 8'h41);
      repeat (2) pulse();
      repeat (10) @(posedge aclk);
      wr(ADDR_CTRL, 8'h40);
      rd(ADDR_CNT_LO, 32'h14, 2);
      rd(ADDR_GATE, 32'hd0, 0);
      wr(ADDR_GATE, 8'hd8);
      wr(ADDR_GATE, 8'hc8);
      rd(ADDR_GATE, 32'hc0, 0);
      $display("test single pulse done");
      for (s = 1; s < 4; s++)
      begin
         seed = xs(seed);
         watchdog_fuse_en <= seed[0];
         wr(ADDR_GATE, {2'h3, s == 3, 3'h0, s[1:0]});
         wr(ADDR_FLAGS, 8'h03);
         repeat (600) @(posedge aclk);
         `CHK(wdt_osc_en, s == 3)
         `CHK(wdt_reset_allow, watchdog_fuse_en)
         rd(ADDR_FLAGS, 32'h2, 0);
      end
      $display("test sources done");
      repeat (4)
      begin
         seed = xs(seed);
         wr(ADDR_CNT_LO, seed[7:0]);
         wr(ADDR_CNT_HI, seed[15:8]);
         rd(ADDR_CNT_LO, {24'h0, seed[7:0]}, 0);
         rd(ADDR_CNT_HI, {24'h0, seed[15:8]}, 0);
      end
      $display("test count access done");
      wr(ADDR_GATE, 8'h00);
      wr(ADDR_CNT_HI, 8'hff);
      wr(ADDR_CNT_LO, 8'hf8);
      wr(ADDR_FLAGS, 8'h03);
      wr(ADDR_IE, 8'h01);
      ext_en <= 1'h1;
      cpu_sleep <= 1'h1;
      wr(ADDR_CTRL, 8'h85);
      for (n = 0; !wake_req && n < 300; n++) @(posedge aclk);
      if (n == 300) tmo();
      `CHK(overflow_irq, 1'h1)
      `CHK(wake_req, 1'h1)
      cpu_sleep <= 1'h0;
      wr(ADDR_CTRL, 8'h84);
      rd(ADDR_FLAGS, 32'h1, 0);
      $display("test sleep wake done");
      wrap_up();
   end
endmodule : test_gtc_timer

bind gtc_timer gtc_monitor gtc_monitor_i (.*);
